// ---- core/lcr_device.sv ----
// Control and status register bank of the display controller-driver.
// Assumes commands arrive as one-cycle strobes from logic on the same clock.
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
// Functional notes
// - Scroll offset six bits, keep 0 to 63.
// - Column pointer 0 to 131, resets zero.
// - Row-block pointer 0 to 8, resets zero.
// - Bias code selects 6..9, default 9.
// - Temperature coefficient code, default 00.
// - Contrast trim eight bits, default C0.
// - Supply control load and pump, default 6.
// - Address control bit 0 enables pointer wrap.
// - Bit 1 step order, bit 2 direction.
// - Display bit 0 inverts pixels.
// - Display bit 1 forces pixels on.
// - Display bit 2 on; clear means sleep.
// - Panel bit 1 mirrors columns.
// - Panel bit 2 mirrors rows.
// - Panel bit 3 picks 80 or 100 fps.
// - Panel bit 4 selects partial multiplex rate.
// - Window rows six bits, default 0, 63.
// - Host keeps scan end, window spacing legal.
// - Operating state reports reset, sleep, normal.
// - Strap field mirrors identification pins.
// - Power-up and system reset load defaults.
// - Settings registers change only through commands.
// - Row and column indices are zero-based.
module lcr_device (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Command link
   lcr_link_if.device link,
   // Strap pins
   input wire logic [1:0] strap_pins,
   // Decoded panel controls
   output logic [5:0] scroll_offset,
   output logic [7:0] column_pointer,
   output logic [3:0] row_block_pointer,
   output logic [1:0] bias_ratio,
   output logic [1:0] temperature_coefficient,
   output logic [7:0] contrast_trim,
   output logic [2:0] supply_control,
   output logic invert_pixels,
   output logic force_all_pixels_on,
   output logic display_on,
   output logic mirror_columns,
   output logic mirror_rows,
   output logic frame_rate_fast,
   output logic [5:0] partial_window_first_row,
   output logic [5:0] partial_window_last_row,
   output logic [5:0] last_scanned_row,
   output logic [6:0] mux_rate,
   output logic [1:0] operating_state
);
   // ==========================================================================
   // State.
   typedef struct packed {
      logic [1:0] strap_meta;
      logic [1:0] strap_sync;
      logic [1:0] om;
      logic [5:0] scroll;
      logic [7:0] column;
      logic [3:0] row_block;
      logic [1:0] bias;
      logic [1:0] temp;
      logic [7:0] contrast;
      logic [2:0] supply;
      logic [2:0] addr_ctrl;
      logic [2:0] disp_ctrl;
      logic [4:0] panel_ctrl;
      logic [5:0] scan_end;
      logic [5:0] win_first;
      logic [5:0] win_last;
      logic [6:0] mux;
      logic [7:0] status;
   } lcr_dev_s;

   lcr_dev_s st_reg;
   lcr_dev_s st_next;
   logic col_end;
   logic row_end;
   logic [3:0] row_stepped;

   // ==========================================================================
   // Next-state logic.
   always_comb begin
      st_next = st_reg;
      st_next.strap_meta = strap_pins;
      st_next.strap_sync = st_reg.strap_meta;
      col_end = (st_reg.column >= lcr_pkg::LCR_COLUMN_MAX);
      row_end = st_reg.addr_ctrl[lcr_pkg::LCR_AC_DIR] ? (st_reg.row_block == 4'h0) :
         (st_reg.row_block >= lcr_pkg::LCR_ROW_BLOCK_MAX);
      if (row_end) begin
         row_stepped = st_reg.addr_ctrl[lcr_pkg::LCR_AC_DIR] ? lcr_pkg::LCR_ROW_BLOCK_MAX :
            4'h0;
      end else if (st_reg.addr_ctrl[lcr_pkg::LCR_AC_DIR]) begin
         row_stepped = st_reg.row_block - 4'h1;
      end else begin
         row_stepped = st_reg.row_block + 4'h1;
      end
      if (link.cmd_valid) begin
         unique case (link.cmd_code)
            lcr_pkg::LCR_CMD_SCROLL: st_next.scroll = link.cmd_data[5:0];
            lcr_pkg::LCR_CMD_COLUMN: st_next.column = link.cmd_data;
            lcr_pkg::LCR_CMD_ROW_BLOCK: st_next.row_block = link.cmd_data[3:0];
            lcr_pkg::LCR_CMD_BIAS: st_next.bias = link.cmd_data[1:0];
            lcr_pkg::LCR_CMD_TEMP: st_next.temp = link.cmd_data[1:0];
            lcr_pkg::LCR_CMD_CONTRAST: st_next.contrast = link.cmd_data;
            lcr_pkg::LCR_CMD_SUPPLY: st_next.supply = link.cmd_data[2:0];
            lcr_pkg::LCR_CMD_ADDR_CTRL: st_next.addr_ctrl = link.cmd_data[2:0];
            lcr_pkg::LCR_CMD_DISP_CTRL: st_next.disp_ctrl = link.cmd_data[2:0];
            lcr_pkg::LCR_CMD_PANEL_CTRL: st_next.panel_ctrl = {link.cmd_data[4:1], 1'b0};
            lcr_pkg::LCR_CMD_SCAN_END: st_next.scan_end = link.cmd_data[5:0];
            lcr_pkg::LCR_CMD_WIN_FIRST: st_next.win_first = link.cmd_data[5:0];
            lcr_pkg::LCR_CMD_WIN_LAST: st_next.win_last = link.cmd_data[5:0];
            lcr_pkg::LCR_CMD_VENDOR: st_next.status = st_reg.status;
            lcr_pkg::LCR_CMD_SYS_RESET: begin
               st_next.scroll = lcr_pkg::LCR_SCROLL_RST;
               st_next.column = lcr_pkg::LCR_COLUMN_RST;
               st_next.row_block = lcr_pkg::LCR_ROW_BLOCK_RST;
               st_next.bias = lcr_pkg::LCR_BIAS_RST;
               st_next.temp = lcr_pkg::LCR_TEMP_RST;
               st_next.contrast = lcr_pkg::LCR_CONTRAST_RST;
               st_next.supply = lcr_pkg::LCR_SUPPLY_RST;
               st_next.addr_ctrl = lcr_pkg::LCR_ADDR_CTRL_RST;
               st_next.disp_ctrl = lcr_pkg::LCR_DISP_CTRL_RST;
               st_next.panel_ctrl = lcr_pkg::LCR_PANEL_CTRL_RST;
               st_next.scan_end = lcr_pkg::LCR_SCAN_END_RST;
               st_next.win_first = lcr_pkg::LCR_WIN_FIRST_RST;
               st_next.win_last = lcr_pkg::LCR_WIN_LAST_RST;
            end
            lcr_pkg::LCR_CMD_ACCESS: begin
               if (st_reg.addr_ctrl[lcr_pkg::LCR_AC_ROW_FIRST]) begin
                  if (!row_end || st_reg.addr_ctrl[lcr_pkg::LCR_AC_WRAP]) begin
                     st_next.row_block = row_stepped;
                  end
                  if (row_end && st_reg.addr_ctrl[lcr_pkg::LCR_AC_WRAP]) begin
                     st_next.column = col_end ? 8'h00 : st_reg.column + 8'h01;
                  end
               end else if (!col_end) begin
                  st_next.column = st_reg.column + 8'h01;
               end else if (st_reg.addr_ctrl[lcr_pkg::LCR_AC_WRAP]) begin
                  st_next.column = 8'h00;
                  st_next.row_block = row_stepped;
               end
            end
         endcase
      end
      // Multiplex rate from the settled registers.
      if (st_reg.panel_ctrl[lcr_pkg::LCR_LC_PARTIAL]) begin
         st_next.mux = {1'b0, st_reg.win_last} - {1'b0, st_reg.win_first} + 7'h01;
      end else begin
         st_next.mux = {1'b0, st_reg.scan_end} + 7'h01;
      end
      // Status byte: strap, mirrors, wrap, display on.
      st_next.status = {st_reg.strap_sync, st_reg.panel_ctrl[lcr_pkg::LCR_LC_MIRROR_COL],
         st_reg.panel_ctrl[lcr_pkg::LCR_LC_MIRROR_ROW], st_reg.addr_ctrl[lcr_pkg::LCR_AC_WRAP],
         st_reg.disp_ctrl[lcr_pkg::LCR_DC_ON], 2'h0};
      // Operating state follows the display switch once out of reset.
      if (st_next.disp_ctrl[lcr_pkg::LCR_DC_ON]) begin
         st_next.om = lcr_pkg::LCR_OM_NORMAL;
      end else begin
         st_next.om = lcr_pkg::LCR_OM_SLEEP;
      end
   end

   // ==========================================================================
   // State register.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_reg <= '{strap_meta: 2'h0, strap_sync: 2'h0, om: lcr_pkg::LCR_OM_RESET,
            scroll: lcr_pkg::LCR_SCROLL_RST, column: lcr_pkg::LCR_COLUMN_RST,
            row_block: lcr_pkg::LCR_ROW_BLOCK_RST, bias: lcr_pkg::LCR_BIAS_RST,
            temp: lcr_pkg::LCR_TEMP_RST, contrast: lcr_pkg::LCR_CONTRAST_RST,
            supply: lcr_pkg::LCR_SUPPLY_RST, addr_ctrl: lcr_pkg::LCR_ADDR_CTRL_RST,
            disp_ctrl: lcr_pkg::LCR_DISP_CTRL_RST, panel_ctrl: lcr_pkg::LCR_PANEL_CTRL_RST,
            scan_end: lcr_pkg::LCR_SCAN_END_RST, win_first: lcr_pkg::LCR_WIN_FIRST_RST,
            win_last: lcr_pkg::LCR_WIN_LAST_RST, mux: lcr_pkg::LCR_MUX_RST,
            status: lcr_pkg::LCR_STATUS_RST};
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================================================
   // Outputs.
   assign scroll_offset = st_reg.scroll;
   assign column_pointer = st_reg.column;
   assign row_block_pointer = st_reg.row_block;
   assign bias_ratio = st_reg.bias;
   assign temperature_coefficient = st_reg.temp;
   assign contrast_trim = st_reg.contrast;
   assign supply_control = st_reg.supply;
   assign invert_pixels = st_reg.disp_ctrl[lcr_pkg::LCR_DC_INVERT];
   assign force_all_pixels_on = st_reg.disp_ctrl[lcr_pkg::LCR_DC_ALL_ON];
   assign display_on = st_reg.disp_ctrl[lcr_pkg::LCR_DC_ON];
   assign mirror_columns = st_reg.panel_ctrl[lcr_pkg::LCR_LC_MIRROR_COL];
   assign mirror_rows = st_reg.panel_ctrl[lcr_pkg::LCR_LC_MIRROR_ROW];
   assign frame_rate_fast = st_reg.panel_ctrl[lcr_pkg::LCR_LC_RATE];
   assign partial_window_first_row = st_reg.win_first;
   assign partial_window_last_row = st_reg.win_last;
   assign last_scanned_row = st_reg.scan_end;
   assign mux_rate = st_reg.mux;
   assign operating_state = st_reg.om;
   assign link.status_data = st_reg.status;
endmodule

// ---- core/lcr_host.sv ----
// Host controller: turns software register writes into link commands.
// Assumes a software port on the same clock as the register bank.
`timescale 1ns/1ps
module lcr_host (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Software port
   input wire logic [3:0] sw_addr,
   input wire logic [15:0] sw_wdata,
   input wire logic sw_write,
   input wire logic sw_read,
   output logic [15:0] sw_rdata,
   // Command link
   lcr_link_if.host link
);
   // ==========================================================================
   // State.
   typedef struct packed {
      logic cmd_valid;
      logic [3:0] cmd_code;
      logic [7:0] cmd_data;
      logic [15:0] rdata;
      logic [15:0] last_cmd;
   } lcr_host_s;

   lcr_host_s st_reg;
   lcr_host_s st_next;

   always_comb begin
      st_next = st_reg;
      st_next.cmd_valid = 1'b0;
      st_next.rdata = 16'h0000;
      if (sw_write && sw_addr == lcr_pkg::LCR_HOST_CMD_OFS) begin
         st_next.cmd_valid = 1'b1;
         st_next.cmd_code = sw_wdata[11:8];
         st_next.cmd_data = sw_wdata[7:0];
         st_next.last_cmd = sw_wdata;
      end
      if (sw_read) begin
         unique case (sw_addr)
            lcr_pkg::LCR_HOST_CMD_OFS: st_next.rdata = st_reg.last_cmd;
            lcr_pkg::LCR_HOST_STATUS_OFS: st_next.rdata = {15'h0000, st_reg.cmd_valid};
            lcr_pkg::LCR_HOST_DEV_OFS: st_next.rdata = {8'h00, link.status_data};
            default: st_next.rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign link.cmd_valid = st_reg.cmd_valid;
   assign link.cmd_code = lcr_pkg::lcr_cmd_e'(st_reg.cmd_code);
   assign link.cmd_data = st_reg.cmd_data;
   assign sw_rdata = st_reg.rdata;
endmodule

// ---- core/lcr_link_if.sv ----
// Command link between host controller and register bank.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface lcr_link_if;
   logic cmd_valid;
   lcr_pkg::lcr_cmd_e cmd_code;
   logic [7:0] cmd_data;
   logic [7:0] status_data;
   modport host (output cmd_valid, output cmd_code, output cmd_data, input status_data);
   modport device (input cmd_valid, input cmd_code, input cmd_data, output status_data);
endinterface

// ---- core/lcr_pkg.sv ----
// Constants and types shared by the register bank and its host controller.
// Assumes a single 125 MHz clock shared by both ends.
package lcr_pkg;
   // ==========================================================================
   // Command codes carried on the link.
   typedef enum logic [3:0] {
      LCR_CMD_SCROLL, LCR_CMD_COLUMN, LCR_CMD_ROW_BLOCK, LCR_CMD_BIAS,
      LCR_CMD_TEMP, LCR_CMD_CONTRAST, LCR_CMD_SUPPLY, LCR_CMD_ADDR_CTRL,
      LCR_CMD_DISP_CTRL, LCR_CMD_PANEL_CTRL, LCR_CMD_SCAN_END, LCR_CMD_WIN_FIRST,
      LCR_CMD_WIN_LAST, LCR_CMD_VENDOR, LCR_CMD_SYS_RESET, LCR_CMD_ACCESS
   } lcr_cmd_e;
   // ==========================================================================
   // Reset values.
   localparam logic [5:0] LCR_SCROLL_RST = 6'h00;
   localparam logic [7:0] LCR_COLUMN_RST = 8'h00;
   localparam logic [3:0] LCR_ROW_BLOCK_RST = 4'h0;
   localparam logic [1:0] LCR_BIAS_RST = 2'h3;
   localparam logic [1:0] LCR_TEMP_RST = 2'h0;
   localparam logic [7:0] LCR_CONTRAST_RST = 8'hC0;
   localparam logic [2:0] LCR_SUPPLY_RST = 3'h6;
   localparam logic [2:0] LCR_ADDR_CTRL_RST = 3'h1;
   localparam logic [2:0] LCR_DISP_CTRL_RST = 3'h0;
   localparam logic [4:0] LCR_PANEL_CTRL_RST = 5'h00;
   localparam logic [5:0] LCR_SCAN_END_RST = 6'h3F;
   localparam logic [5:0] LCR_WIN_FIRST_RST = 6'h00;
   localparam logic [5:0] LCR_WIN_LAST_RST = 6'h3F;
   localparam logic [6:0] LCR_MUX_RST = 7'h40;
   localparam logic [7:0] LCR_STATUS_RST = 8'h08;
   // ==========================================================================
   // Pointer limits and field positions.
   localparam logic [7:0] LCR_COLUMN_MAX = 8'h83;
   localparam logic [3:0] LCR_ROW_BLOCK_MAX = 4'h8;
   localparam int LCR_AC_WRAP = 0;
   localparam int LCR_AC_ROW_FIRST = 1;
   localparam int LCR_AC_DIR = 2;
   localparam int LCR_DC_INVERT = 0;
   localparam int LCR_DC_ALL_ON = 1;
   localparam int LCR_DC_ON = 2;
   localparam int LCR_LC_MIRROR_COL = 1;
   localparam int LCR_LC_MIRROR_ROW = 2;
   localparam int LCR_LC_RATE = 3;
   localparam int LCR_LC_PARTIAL = 4;
   localparam int LCR_WIN_MIN_GAP = 9;
   // ==========================================================================
   // Operating state codes.
   localparam logic [1:0] LCR_OM_RESET = 2'h0;
   localparam logic [1:0] LCR_OM_SLEEP = 2'h2;
   localparam logic [1:0] LCR_OM_NORMAL = 2'h3;
   // ==========================================================================
   // Host register map, word offsets on the software port.
   localparam logic [3:0] LCR_HOST_CMD_OFS = 4'h0;
   localparam logic [3:0] LCR_HOST_STATUS_OFS = 4'h1;
   localparam logic [3:0] LCR_HOST_DEV_OFS = 4'h2;
endpackage

// ---- test/lcr_link_monitor.sv ----
// Assertions on the command link between host controller and register bank.
// Assumes one clock and the status layout {strap, mirrors, wrap, display on, 00}.
`timescale 1ns/1ps
module lcr_link_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Link signals
   input wire logic cmd_valid,
   input wire lcr_pkg::lcr_cmd_e cmd_code,
   input wire logic [7:0] cmd_data,
   input wire logic [7:0] status_data
);
   // ==========================================================================
   // Properties.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   property p_pad_zero;
      status_data[1:0] == 2'h0;
   endproperty
   property p_mirror_col;
      cmd_valid && cmd_code == lcr_pkg::LCR_CMD_PANEL_CTRL
         |-> ##2 status_data[5] == $past(cmd_data[1], 2);
   endproperty
   property p_mirror_row;
      cmd_valid && cmd_code == lcr_pkg::LCR_CMD_PANEL_CTRL
         |-> ##2 status_data[4] == $past(cmd_data[2], 2);
   endproperty
   property p_wrap;
      cmd_valid && cmd_code == lcr_pkg::LCR_CMD_ADDR_CTRL
         |-> ##2 status_data[3] == $past(cmd_data[0], 2);
   endproperty
   property p_disp;
      cmd_valid && cmd_code == lcr_pkg::LCR_CMD_DISP_CTRL
         |-> ##2 status_data[2] == $past(cmd_data[2], 2);
   endproperty
   property p_sysrst;
      cmd_valid && cmd_code == lcr_pkg::LCR_CMD_SYS_RESET |-> ##2 status_data[5:2] == 4'h2;
   endproperty
   property p_quiet;
      !$past(cmd_valid, 2) |-> $stable(status_data[5:2]);
   endproperty
   property p_vendor;
      cmd_valid && cmd_code == lcr_pkg::LCR_CMD_VENDOR ##1 !cmd_valid
         |-> ##1 $stable(status_data[5:2]);
   endproperty
   // ==========================================================================
   // Assertions and covers.
   a_pad_zero: assert property (p_pad_zero) else $error("status padding not zero");
   a_mirror_col: assert property (p_mirror_col) else $error("column mirror wrong");
   a_mirror_row: assert property (p_mirror_row) else $error("row mirror wrong");
   a_wrap: assert property (p_wrap) else $error("wrap flag wrong");
   a_disp: assert property (p_disp) else $error("display flag wrong");
   a_sysrst: assert property (p_sysrst) else $error("defaults not loaded");
   a_quiet: assert property (p_quiet) else $error("status moved alone");
   a_vendor: assert property (p_vendor) else $error("vendor command had effect");
   c_panel: cover property (cmd_valid && cmd_code == lcr_pkg::LCR_CMD_PANEL_CTRL);
   c_sysrst: cover property (cmd_valid && cmd_code == lcr_pkg::LCR_CMD_SYS_RESET);
   c_vendor: cover property (cmd_valid && cmd_code == lcr_pkg::LCR_CMD_VENDOR);
endmodule

// ---- test/testbench.sv ----
// Self-checking bench joining the host controller and the register bank.
// Assumes status_data shows in the low byte of the device status word.
`timescale 1ns/1ps
module testbench;
   // ==========================================================================
   // Signals.
   logic clk, reset_n, sw_write, sw_read;
   logic [3:0] sw_addr;
   logic [15:0] sw_wdata, sw_rdata, rd_word;
   logic [1:0] strap_pins, bias_ratio, temperature_coefficient, operating_state;
   logic [5:0] scroll_offset, partial_window_first_row, partial_window_last_row;
   logic [5:0] last_scanned_row;
   logic [7:0] column_pointer, contrast_trim;
   logic [3:0] row_block_pointer;
   logic [2:0] supply_control;
   logic [6:0] mux_rate;
   logic invert_pixels, force_all_pixels_on, display_on;
   logic mirror_columns, mirror_rows, frame_rate_fast;
   int num_errors, checks_done;
   lcr_link_if link ();
   lcr_host lcr_host_i (.clk(clk), .reset_n(reset_n), .sw_addr(sw_addr),
      .sw_wdata(sw_wdata), .sw_write(sw_write), .sw_read(sw_read),
      .sw_rdata(sw_rdata), .link(link));
   lcr_device lcr_device_i (.clk(clk), .reset_n(reset_n), .link(link),
      .strap_pins(strap_pins), .scroll_offset(scroll_offset),
      .column_pointer(column_pointer), .row_block_pointer(row_block_pointer),
      .bias_ratio(bias_ratio), .temperature_coefficient(temperature_coefficient),
      .contrast_trim(contrast_trim), .supply_control(supply_control),
      .invert_pixels(invert_pixels), .force_all_pixels_on(force_all_pixels_on),
      .display_on(display_on), .mirror_columns(mirror_columns),
      .mirror_rows(mirror_rows), .frame_rate_fast(frame_rate_fast),
      .partial_window_first_row(partial_window_first_row),
      .partial_window_last_row(partial_window_last_row),
      .last_scanned_row(last_scanned_row), .mux_rate(mux_rate),
      .operating_state(operating_state));
   lcr_link_monitor lcr_link_monitor_i (.clk(clk), .reset_n(reset_n),
      .cmd_valid(link.cmd_valid), .cmd_code(link.cmd_code),
      .cmd_data(link.cmd_data), .status_data(link.status_data));
   // ==========================================================================
   // Shared tasks.
   task automatic ck(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmd(input logic [3:0] code, input logic [7:0] data);
      @(posedge clk);
      sw_addr <= lcr_pkg::LCR_HOST_CMD_OFS;
      sw_wdata <= {4'h0, code, data};
      sw_write <= 1'b1;
      @(posedge clk);
      sw_write <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      sw_addr <= a;
      sw_read <= 1'b1;
      @(posedge clk);
      sw_read <= 1'b0;
      #1 rd_word = sw_rdata;
   endtask
   task automatic conclude();
      if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // ==========================================================================
   // Scenarios.
   task automatic t_defaults();
      ck(bias_ratio, 8'h03);
      ck(temperature_coefficient, 8'h00);
      ck(contrast_trim, 8'hC0);
      ck(supply_control, 8'h06);
      ck({2'h0, scroll_offset}, 8'h00);
      ck({4'h0, row_block_pointer}, 8'h00);
      ck(column_pointer, 8'h00);
      ck({invert_pixels, force_all_pixels_on, display_on}, 8'h00);
      ck({mirror_columns, mirror_rows, frame_rate_fast}, 8'h00);
      ck(last_scanned_row, 8'h3F);
      ck({2'h0, partial_window_first_row}, 8'h00);
      ck({2'h0, partial_window_last_row}, 8'h3F);
      ck(mux_rate, 8'h40);
      ck(operating_state, 8'h02);
   endtask
   task automatic t_fields();
      cmd(lcr_pkg::LCR_CMD_SCROLL, 8'h3F);
      ck(scroll_offset, 8'h3F);
      cmd(lcr_pkg::LCR_CMD_COLUMN, 8'h83);
      ck(column_pointer, 8'h83);
      cmd(lcr_pkg::LCR_CMD_ROW_BLOCK, 8'h08);
      ck(row_block_pointer, 8'h08);
      for (int i = 0; i < 4; i++) begin
         cmd(lcr_pkg::LCR_CMD_BIAS, 8'(i));
         ck(bias_ratio, 8'(i));
      end
      cmd(lcr_pkg::LCR_CMD_TEMP, 8'h02);
      ck(temperature_coefficient, 8'h02);
      cmd(lcr_pkg::LCR_CMD_CONTRAST, 8'h5A);
      ck(contrast_trim, 8'h5A);
      cmd(lcr_pkg::LCR_CMD_SUPPLY, 8'h01);
      ck(supply_control, 8'h01);
   endtask
   task automatic t_ctrl();
      cmd(lcr_pkg::LCR_CMD_DISP_CTRL, 8'h01);
      ck({invert_pixels, force_all_pixels_on, display_on}, 8'h04);
      cmd(lcr_pkg::LCR_CMD_DISP_CTRL, 8'h02);
      ck({invert_pixels, force_all_pixels_on, display_on}, 8'h02);
      cmd(lcr_pkg::LCR_CMD_DISP_CTRL, 8'h04);
      ck({display_on, operating_state}, 8'h07);
      cmd(lcr_pkg::LCR_CMD_PANEL_CTRL, 8'h0E);
      ck({mirror_columns, mirror_rows, frame_rate_fast}, 8'h07);
      cmd(lcr_pkg::LCR_CMD_DISP_CTRL, 8'h00);
      ck(operating_state, 8'h02);
   endtask
   task automatic t_partial();
      cmd(lcr_pkg::LCR_CMD_WIN_FIRST, 8'h05);
      cmd(lcr_pkg::LCR_CMD_WIN_LAST, 8'h14);
      cmd(lcr_pkg::LCR_CMD_PANEL_CTRL, 8'h10);
      ck(mux_rate, 8'h10);
      cmd(lcr_pkg::LCR_CMD_SCAN_END, 8'h28);
      cmd(lcr_pkg::LCR_CMD_PANEL_CTRL, 8'h00);
      ck(mux_rate, 8'h29);
   endtask
   task automatic t_step();
      cmd(lcr_pkg::LCR_CMD_ADDR_CTRL, 8'h01);
      cmd(lcr_pkg::LCR_CMD_ROW_BLOCK, 8'h00);
      cmd(lcr_pkg::LCR_CMD_COLUMN, 8'h82);
      cmd(lcr_pkg::LCR_CMD_ACCESS, 8'h00);
      ck(column_pointer, 8'h83);
      cmd(lcr_pkg::LCR_CMD_ACCESS, 8'h00);
      ck({column_pointer[3:0], row_block_pointer}, 8'h01);
      cmd(lcr_pkg::LCR_CMD_ADDR_CTRL, 8'h00);
      cmd(lcr_pkg::LCR_CMD_COLUMN, 8'h83);
      cmd(lcr_pkg::LCR_CMD_ACCESS, 8'h00);
      ck(column_pointer, 8'h83);
      cmd(lcr_pkg::LCR_CMD_ADDR_CTRL, 8'h07);
      cmd(lcr_pkg::LCR_CMD_ROW_BLOCK, 8'h00);
      cmd(lcr_pkg::LCR_CMD_ACCESS, 8'h00);
      ck(row_block_pointer, 8'h08);
   endtask
   task automatic t_reset_cmd();
      cmd(lcr_pkg::LCR_CMD_CONTRAST, 8'h11);
      cmd(lcr_pkg::LCR_CMD_VENDOR, 8'h55);
      ck(contrast_trim, 8'h11);
      cmd(lcr_pkg::LCR_CMD_SYS_RESET, 8'h00);
      t_defaults();
   endtask
   task automatic t_status();
      @(posedge clk);
      strap_pins <= 2'b10;
      repeat (4) @(posedge clk);
      rd(lcr_pkg::LCR_HOST_DEV_OFS);
      ck(rd_word[7:0], 8'h88);
      rd(4'h3);
      ck(rd_word[7:0], 8'h00);
      rd(lcr_pkg::LCR_HOST_CMD_OFS);
      ck(rd_word[15:8], 8'h0E);
      rd(lcr_pkg::LCR_HOST_STATUS_OFS);
      ck(rd_word[7:0], 8'h00);
   endtask
   // ==========================================================================
   // Clock, sequence and watchdog.
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      reset_n = 1'b0;
      {sw_write, sw_read, sw_addr, sw_wdata, strap_pins} = '0;
      repeat (2) @(posedge clk);
      ck(operating_state, 8'h00);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      t_defaults();
      t_fields();
      t_ctrl();
      t_partial();
      t_step();
      t_reset_cmd();
      t_status();
      conclude();
   end
   initial begin
      #100000;
      num_errors++;
      conclude();
   end
endmodule
